// [link_error_monitor.sv]
// Link error monitor with Wishbone register access
`timescale 1ns/1ps
`default_nettype none

// What this block does
// RL1: Fault sets station flag and stores code
// RL2: Eight code registers, indexed by station number
// RL3: Master: no reply in time gives 01H
// RL4: Master: wrong slave answers gives 02H
// RL5: Master: counter mismatch gives 03H
// RL6: Malformed slave reply gives 04H anywhere
// RL7: Slave: master poll overdue gives 11H
// RL8: Slave: malformed master message gives 14H
// RL9: Observing slave: 21H absent, 22H wrong, 23H count
// RL10: Poll before parameters gives 31H on self
// RL11: Running flag high throughout data transfer
// RL12: Master flag raised only on slaves
// RL13: Per-slave flags; own faults not flagged except 31H
// RL14: Station zero master, one to seven slaves
// RL15: Separate serial error flags per channel
// RL16: Software picks channel through select bit
// RL17: Flags and codes clear only at start
// RL18: Monitoring time settable, default five
// RL19: Code register keeps latest code only
module link_error_monitor
   import link_err_pkg::*;
#(
   parameter int MON_UNIT = MON_UNIT_CYC
) (
   input  wire logic        clk_in,
   input  wire logic        rst_b_in,
   input  wire logic        wb_cyc_in,
   input  wire logic        wb_stb_in,
   input  wire logic        wb_we_in,
   input  wire logic [7:0]  wb_adr_in,
   input  wire logic [3:0]  wb_sel_in,
   input  wire logic [31:0] wb_dat_in,
   output logic      [31:0] wb_dat_out,
   output logic             wb_ack_out,
   input  wire logic        run_mode_in,
   input  wire logic        xfer_active_in,
   input  wire logic        param_rx_in,
   input  wire logic [1:0]  ser_abn_in,
   input  wire logic        mon_start_in,
   input  wire logic [2:0]  mon_target_in,
   input  wire logic        mon_stop_in,
   input  wire fault_ev_t   fault_in,
   output logic             channel_select_out,
   output logic             irq_out
);

   // ************************************************************
   // Decoding helpers
   // ************************************************************
   function automatic logic [3:0] reg_index(input logic [7:0] adr);
      logic [3:0] idx;
      idx = 4'hF;
      case (adr)
         OFS_CTRL:     idx = 4'h8;
         OFS_STAT:     idx = 4'h9;
         OFS_IRQ_STAT: idx = 4'hA;
         OFS_IRQ_MASK: idx = 4'hB;
         default: begin
            if (adr[7:5] == OFS_CODE_BASE[7:5] && adr[1:0] == 2'h0) begin
               idx = {1'b0, adr[4:2]};
            end
         end
      endcase
      return idx;
   endfunction : reg_index

   function automatic logic [7:0] code_of(input fault_kind_t k,
                                          input logic master,
                                          input logic [2:0] stn);
      logic [7:0] c;
      c = 8'h00;
      case (k)
         K_TIMEOUT: begin
            if (master) begin
               c = EC_M_TIMEOUT;                              // [RL3]
            end else if (stn == MASTER_STN) begin
               c = EC_S_TIMEOUT;                              // [RL7]
            end else begin
               c = EC_O_ABSENT;                               // [RL9]
            end
         end
         K_WRONG: begin
            if (master) begin
               c = EC_M_WRONG;                                // [RL4]
            end else begin
               c = EC_O_WRONG;                                // [RL9]
            end
         end
         K_COUNT: begin
            if (master) begin
               c = EC_M_COUNT;                                // [RL5]
            end else begin
               c = EC_O_COUNT;                                // [RL9]
            end
         end
         K_FORMAT: begin
            if (!master && stn == MASTER_STN) begin
               c = EC_S_FORMAT;                               // [RL8]
            end else begin
               c = EC_FORMAT;                                 // [RL6]
            end
         end
         K_NOPARAM: c = EC_NO_PARAM;                          // [RL10]
         default:   c = 8'h00;
      endcase
      return c;
   endfunction : code_of

   // ************************************************************
   // Registers
   // ************************************************************
   logic              chsel_r;
   logic [2:0]        stn_r;
   logic [7:0]        mon_time_r;
   logic [IRQ_W-1:0]  irq_stat_r;
   logic [IRQ_W-1:0]  irq_mask_r;
   logic              param_r;
   logic [1:0]        ser_err_r;
   logic              run_r;
   logic [7:0]        seq_flag_r;
   logic [7:0]        code_r [8];
   logic              run_mode_d_r;
   logic              ack_r;
   logic [31:0]       rdat_r;
   logic              irq_r;
   mon_state_t        mon_st_r;
   logic [2:0]        mon_tgt_r;
   logic [7:0]        mon_units_r;
   logic [31:0]       mon_cyc_r;

   logic              is_master;
   logic              start_clr;
   logic              wb_req;
   logic              wb_wr;
   logic [3:0]        widx;
   logic              mon_expire;
   fault_kind_t       kind;
   logic [2:0]        ev_stn;
   logic              ev_valid;
   logic              flag_ok;
   logic [IRQ_W-1:0]  irq_set;
   logic [31:0]       rdat_nxt;

   assign is_master = (stn_r == MASTER_STN);                  // [RL14]
   assign start_clr = run_mode_in & ~run_mode_d_r;
   assign wb_req    = wb_cyc_in & wb_stb_in & ~ack_r;
   assign wb_wr     = wb_req & wb_we_in;
   assign widx      = reg_index(wb_adr_in);

   // ************************************************************
   // No-response monitoring timer
   // ************************************************************
   assign mon_expire = (mon_st_r == T_RUN) && !mon_stop_in &&
                       (mon_units_r == 8'h00) && (mon_cyc_r == 32'h0);

   always_ff @(posedge clk_in) begin
      if (!rst_b_in) begin
         mon_st_r    <= T_IDLE;
         mon_tgt_r   <= 3'h0;
         mon_units_r <= 8'h00;
         mon_cyc_r   <= 32'h0;
      end else begin
         case (mon_st_r)
            T_IDLE: begin
               if (mon_start_in) begin
                  mon_st_r    <= T_RUN;
                  mon_tgt_r   <= mon_target_in;
                  mon_units_r <= mon_time_r - 8'h01;          // [RL18]
                  mon_cyc_r   <= 32'(MON_UNIT - 1);
               end
            end
            T_RUN: begin
               if (mon_stop_in || mon_expire) begin
                  mon_st_r <= T_IDLE;
               end else if (mon_cyc_r != 32'h0) begin
                  mon_cyc_r <= mon_cyc_r - 32'h1;
               end else begin
                  mon_units_r <= mon_units_r - 8'h01;
                  mon_cyc_r   <= 32'(MON_UNIT - 1);
               end
            end
            default: mon_st_r <= T_IDLE;
         endcase
      end
   end

   // ************************************************************
   // Fault selection, one per cycle in fixed priority
   // ************************************************************
   always_comb begin
      kind   = K_NONE;
      ev_stn = fault_in.station;
      if (mon_expire) begin
         kind   = K_TIMEOUT;
         ev_stn = mon_tgt_r;
      end else if (fault_in.noparam && !is_master) begin
         kind   = K_NOPARAM;
         ev_stn = stn_r;                                      // [RL10]
      end else if (fault_in.format) begin
         kind = K_FORMAT;
      end else if (fault_in.wrong) begin
         kind = K_WRONG;
      end else if (fault_in.count) begin
         kind = K_COUNT;
      end
   end

   assign ev_valid = (kind != K_NONE);
   // Master flag only on slaves; a slave flags itself only for 31H
   always_comb begin
      if (ev_stn == MASTER_STN) begin
         flag_ok = !is_master;                                // [RL12]
      end else begin
         flag_ok = (ev_stn != stn_r) || (kind == K_NOPARAM);  // [RL13]
      end
   end

   // ************************************************************
   // Sequence error flags and code registers
   // ************************************************************
   genvar g;
   generate
      for (g = 0; g < 8; g++) begin : g_stn
         always_ff @(posedge clk_in) begin
            if (!rst_b_in) begin
               seq_flag_r[g] <= 1'b0;
               code_r[g]     <= 8'h00;
            end else if (ev_valid && flag_ok && ev_stn == 3'(g)) begin
               seq_flag_r[g] <= 1'b1;                         // [RL1]
               code_r[g]     <= code_of(kind, is_master, ev_stn); // [RL19]
            end else if (start_clr) begin
               seq_flag_r[g] <= 1'b0;                         // [RL17]
               code_r[g]     <= 8'h00;
            end
         end
      end
   endgenerate

   // ************************************************************
   // Serial, parameter and transfer status
   // ************************************************************
   generate
      for (g = 0; g < 2; g++) begin : g_ser
         always_ff @(posedge clk_in) begin
            if (!rst_b_in) begin
               ser_err_r[g] <= 1'b0;
            end else if (ser_abn_in[g]) begin
               ser_err_r[g] <= 1'b1;                          // [RL15]
            end else if (start_clr) begin
               ser_err_r[g] <= 1'b0;                          // [RL17]
            end
         end
      end
   endgenerate

   always_ff @(posedge clk_in) begin
      if (!rst_b_in) begin
         param_r      <= 1'b0;
         run_r        <= 1'b0;
         run_mode_d_r <= 1'b0;
      end else begin
         param_r      <= param_rx_in;
         run_r        <= xfer_active_in;                      // [RL11]
         run_mode_d_r <= run_mode_in;
      end
   end

   // ************************************************************
   // Control registers
   // ************************************************************
   always_ff @(posedge clk_in) begin
      if (!rst_b_in) begin
         chsel_r    <= 1'b0;
         stn_r      <= STN_RST;
         mon_time_r <= MON_TIME_RST;
      end else if (wb_wr && widx == 4'h8) begin
         if (wb_sel_in[0]) begin
            chsel_r <= wb_dat_in[CTRL_CHSEL];                 // [RL16]
         end
         if (wb_sel_in[1]) begin
            stn_r <= wb_dat_in[CTRL_STN_LSB +: 3];
         end
         if (wb_sel_in[2]) begin
            mon_time_r <= wb_dat_in[CTRL_MON_LSB +: 8];       // [RL18]
         end
      end
   end

   // ************************************************************
   // Interrupt status and mask
   // ************************************************************
   assign irq_set = {ser_abn_in[1], ser_abn_in[0], ev_valid & flag_ok};

   always_ff @(posedge clk_in) begin
      if (!rst_b_in) begin
         irq_stat_r <= '0;
      end else if (wb_wr && widx == 4'hA && wb_sel_in[0]) begin
         irq_stat_r <= (irq_stat_r & ~wb_dat_in[IRQ_W-1:0]) | irq_set;
      end else begin
         irq_stat_r <= irq_stat_r | irq_set;
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rst_b_in) begin
         irq_mask_r <= '0;
      end else if (wb_wr && widx == 4'hB && wb_sel_in[0]) begin
         irq_mask_r <= wb_dat_in[IRQ_W-1:0];
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rst_b_in) begin
         irq_r <= 1'b0;
      end else begin
         irq_r <= |(irq_stat_r & irq_mask_r);
      end
   end

   // ************************************************************
   // Read data selection
   // ************************************************************
   always_comb begin
      rdat_nxt = 32'h0;
      case (widx)
         4'h8: begin
            rdat_nxt[CTRL_CHSEL]        = chsel_r;
            rdat_nxt[CTRL_STN_LSB +: 3] = stn_r;
            rdat_nxt[CTRL_MON_LSB +: 8] = mon_time_r;
         end
         4'h9: begin
            rdat_nxt[ST_PARAM]          = param_r;
            rdat_nxt[ST_SER1]           = ser_err_r[0];
            rdat_nxt[ST_SER2]           = ser_err_r[1];
            rdat_nxt[ST_RUN]            = run_r;
            rdat_nxt[ST_MSEQ]           = seq_flag_r[0];
            rdat_nxt[ST_SSEQ_LSB +: 7]  = seq_flag_r[7:1];
         end
         4'hA: begin
            rdat_nxt[IRQ_W-1:0] = irq_stat_r;
         end
         4'hB: begin
            rdat_nxt[IRQ_W-1:0] = irq_mask_r;
         end
         4'hC, 4'hD, 4'hE, 4'hF: begin
            rdat_nxt = 32'h0;
         end
         default: begin
            rdat_nxt[7:0] = code_r[widx[2:0]];                // [RL2]
         end
      endcase
   end

   // ************************************************************
   // Wishbone answer
   // ************************************************************
   always_ff @(posedge clk_in) begin
      if (!rst_b_in) begin
         ack_r  <= 1'b0;
         rdat_r <= 32'h0;
      end else begin
         ack_r <= wb_req;
         if (wb_req && !wb_we_in) begin
            rdat_r <= rdat_nxt;
         end
      end
   end

   assign wb_ack_out         = ack_r;
   assign wb_dat_out         = rdat_r;
   assign irq_out            = irq_r;
   assign channel_select_out = chsel_r;

endmodule : link_error_monitor
`default_nettype wire

// [link_err_pkg.sv]
// Constants and types for the link error monitor
package link_err_pkg;
   localparam int          CLK_MHZ       = 200;
   // No-response time unit in ps; count of clocks derived from it
   localparam int          MON_UNIT_NS   = 10000000;
   localparam int          MON_UNIT_CYC  = MON_UNIT_NS / 1000 * CLK_MHZ / 1000;
   localparam logic [7:0]  MON_TIME_RST  = 8'h05;
   localparam logic [2:0]  STN_RST       = 3'h0;
   localparam logic [2:0]  MASTER_STN    = 3'h0;
   // Register byte offsets
   localparam logic [7:0]  OFS_CTRL      = 8'h00;
   localparam logic [7:0]  OFS_STAT      = 8'h04;
   localparam logic [7:0]  OFS_IRQ_STAT  = 8'h08;
   localparam logic [7:0]  OFS_IRQ_MASK  = 8'h0C;
   localparam logic [7:0]  OFS_CODE_BASE = 8'h20;
   // Control fields
   localparam int          CTRL_CHSEL    = 0;
   localparam int          CTRL_STN_LSB  = 8;
   localparam int          CTRL_MON_LSB  = 16;
   // Status fields
   localparam int          ST_PARAM      = 0;
   localparam int          ST_SER1       = 1;
   localparam int          ST_SER2       = 2;
   localparam int          ST_RUN        = 3;
   localparam int          ST_MSEQ       = 4;
   localparam int          ST_SSEQ_LSB   = 5;
   // Interrupt status bits
   localparam int          IRQ_SEQ       = 0;
   localparam int          IRQ_SER1      = 1;
   localparam int          IRQ_SER2      = 2;
   localparam int          IRQ_W         = 3;
   // Error codes
   localparam logic [7:0]  EC_M_TIMEOUT  = 8'h01;
   localparam logic [7:0]  EC_M_WRONG    = 8'h02;
   localparam logic [7:0]  EC_M_COUNT    = 8'h03;
   localparam logic [7:0]  EC_FORMAT     = 8'h04;
   localparam logic [7:0]  EC_S_TIMEOUT  = 8'h11;
   localparam logic [7:0]  EC_S_FORMAT   = 8'h14;
   localparam logic [7:0]  EC_O_ABSENT   = 8'h21;
   localparam logic [7:0]  EC_O_WRONG    = 8'h22;
   localparam logic [7:0]  EC_O_COUNT    = 8'h23;
   localparam logic [7:0]  EC_NO_PARAM   = 8'h31;

   typedef enum logic [2:0] {
      K_NONE    = 3'b000,
      K_TIMEOUT = 3'b001,
      K_WRONG   = 3'b010,
      K_COUNT   = 3'b011,
      K_FORMAT  = 3'b100,
      K_NOPARAM = 3'b101
   } fault_kind_t;

   // Fault report from the link engine, one cycle pulse fields
   typedef struct packed {
      logic       wrong;
      logic       count;
      logic       format;
      logic       noparam;
      logic [2:0] station;
   } fault_ev_t;

   typedef enum logic [0:0] {
      T_IDLE = 1'b0,
      T_RUN  = 1'b1
   } mon_state_t;
endpackage : link_err_pkg

// [link_error_monitor_checker.sv]
// Port-level assertions for the link error monitor
`timescale 1ns/1ps
`default_nettype none
module link_error_monitor_checker
   import link_err_pkg::*;
#(
   parameter int MON_UNIT = MON_UNIT_CYC
) (
   input wire logic        clk_in,
   input wire logic        rst_b_in,
   input wire logic        wb_cyc_in,
   input wire logic        wb_stb_in,
   input wire logic        wb_we_in,
   input wire logic [7:0]  wb_adr_in,
   input wire logic [3:0]  wb_sel_in,
   input wire logic [31:0] wb_dat_in,
   input wire logic [31:0] wb_dat_out,
   input wire logic        wb_ack_out,
   input wire logic        run_mode_in,
   input wire logic        xfer_active_in,
   input wire logic        param_rx_in,
   input wire logic [1:0]  ser_abn_in,
   input wire logic        mon_start_in,
   input wire logic [2:0]  mon_target_in,
   input wire logic        mon_stop_in,
   input wire fault_ev_t   fault_in,
   input wire logic        channel_select_out,
   input wire logic        irq_out
);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_b_in);
   logic take;
   logic wctl;
   logic hole;
   assign take = wb_cyc_in & wb_stb_in & ~wb_ack_out;
   assign wctl = take & wb_we_in & (wb_adr_in == OFS_CTRL);
   assign hole = (wb_adr_in[1:0] == 2'h0) & (wb_adr_in > OFS_IRQ_MASK)
                 & (wb_adr_in < OFS_CODE_BASE);
   // ****************************************
   // Bus handshake and registers
   // ****************************************
   ack_pulse_a: assert property (wb_ack_out |=> !wb_ack_out)
      else $error("ack longer than one cycle");
   ack_resp_a: assert property (take |=> wb_ack_out)
      else $error("request not answered next cycle");
   ack_idle_a: assert property (!wb_cyc_in |=> !wb_ack_out)
      else $error("ack without request");
   chsel_write_a: assert property (wctl && wb_sel_in[0] |=> ##1
      channel_select_out == $past(wb_dat_in[CTRL_CHSEL], 2))
      else $error("channel select not written");
   chsel_hold_a: assert property (!wctl [*3] |->
      $stable(channel_select_out)) else $error("channel select changed");
   unmapped_rd_a: assert property (take && !wb_we_in && hole
      |=> wb_dat_out == 32'h0) else $error("unmapped read not zero");
   irq_reset_a: assert property ($rose(rst_b_in) |-> !irq_out)
      else $error("irq high after reset");
   run_flag_a: assert property (take && !wb_we_in &&
      wb_adr_in == OFS_STAT && $stable(xfer_active_in) && $past(rst_b_in)
      |=> wb_dat_out[ST_RUN] == $past(xfer_active_in))
      else $error("running flag wrong");
   c_stat_rd: cover property (take && !wb_we_in && wb_adr_in == OFS_STAT);
   c_irq: cover property ($rose(irq_out));
   c_fmt: cover property (fault_in.format);
endmodule : link_error_monitor_checker

bind link_error_monitor link_error_monitor_checker #(.MON_UNIT(MON_UNIT))
   i_chk (.clk_in(clk_in), .rst_b_in(rst_b_in), .wb_cyc_in(wb_cyc_in),
   .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in),
   .wb_sel_in(wb_sel_in), .wb_dat_in(wb_dat_in), .wb_dat_out(wb_dat_out),
   .wb_ack_out(wb_ack_out), .run_mode_in(run_mode_in),
   .xfer_active_in(xfer_active_in), .param_rx_in(param_rx_in),
   .ser_abn_in(ser_abn_in), .mon_start_in(mon_start_in),
   .mon_target_in(mon_target_in), .mon_stop_in(mon_stop_in),
   .fault_in(fault_in), .channel_select_out(channel_select_out),
   .irq_out(irq_out));
`default_nettype wire

// [link_peer.sv]
// Peer station model driving link events into the monitor
`timescale 1ns/1ps
`default_nettype none
module link_peer
   import link_err_pkg::*;
(
   input  wire logic  clk_in,
   output fault_ev_t  fault_out,
   output logic       start_out,
   output logic [2:0] target_out,
   output logic       stop_out,
   output logic [1:0] abn_out
);
   initial begin
      fault_out <= '0;
      start_out <= 1'b0;
      target_out <= 3'h0;
      stop_out <= 1'b0;
      abn_out <= 2'h0;
   end
   // One fault pulse, station field scrambled afterwards
   task automatic fault(input int k, input logic [2:0] s);
      fault_ev_t f;
      f = '0;
      f.station = s;
      f.wrong = (k == 0);
      f.count = (k == 1);
      f.format = (k == 2);
      f.noparam = (k == 3);
      fault_out <= f;
      @(posedge clk_in);
      fault_out <= {4'h0, ~s};
   endtask : fault
   // Poll a station, answer after dly cycles or never
   task automatic poll(input logic [2:0] t, input int dly, input logic rep);
      start_out <= 1'b1;
      target_out <= t;
      @(posedge clk_in);
      start_out <= 1'b0;
      target_out <= ~t;
      repeat (dly) @(posedge clk_in);
      if (rep) begin
         stop_out <= 1'b1;
         @(posedge clk_in);
         stop_out <= 1'b0;
      end
   endtask : poll
   task automatic abn(input logic [1:0] c);
      abn_out <= c;
      @(posedge clk_in);
      abn_out <= 2'h0;
   endtask : abn
endmodule : link_peer
`default_nettype wire

// [link_error_monitor_tb.sv]
// Self-checking bench for the link error monitor
`timescale 1ns/1ps
`default_nettype none
module link_error_monitor_tb;
   import link_err_pkg::*;
   localparam int MU = 4;
   logic clk_in, rst_b_in, cyc, stb, we, run, xfer, par, chs, irq, st, sp, ack;
   logic s1, s2, c;
   logic [7:0] adr, ef, mt;
   logic [7:0] ec [8];
   logic [31:0] wdat, rdat, q;
   logic [2:0] tg, own;
   logic [1:0] abn;
   fault_ev_t flt;
   int miscompares, comparisons, seed;
   link_error_monitor #(.MON_UNIT(MU)) i_link_error_monitor (
      .clk_in(clk_in), .rst_b_in(rst_b_in), .wb_cyc_in(cyc), .wb_stb_in(stb),
      .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(4'hF), .wb_dat_in(wdat),
      .wb_dat_out(rdat), .wb_ack_out(ack), .run_mode_in(run),
      .xfer_active_in(xfer), .param_rx_in(par), .ser_abn_in(abn),
      .mon_start_in(st), .mon_target_in(tg), .mon_stop_in(sp),
      .fault_in(flt), .channel_select_out(chs), .irq_out(irq));
   link_peer i_link_peer (.clk_in(clk_in), .fault_out(flt), .start_out(st),
      .target_out(tg), .stop_out(sp), .abn_out(abn));
   initial begin
      clk_in = 1'b0;
      forever #2.5 clk_in = ~clk_in;
   end
   task automatic end_sim();
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : end_sim
   task automatic chk(input logic [31:0] g, input logic [31:0] e, string m);
      comparisons++;
      if (g !== e) begin
         miscompares++;
         $display("CHECK FAILED %0t %s got %h exp %h", $time, m, g, e);
      end
   endtask : chk
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d;
      n = 0;
      do begin @(posedge clk_in); n++; end while (ack !== 1'b1 && n < 20);
      if (ack !== 1'b1) begin miscompares++; end_sim(); end
      q = rdat;
      cyc <= 1'b0; stb <= 1'b0;
      @(posedge clk_in);
   endtask : bus
   task automatic rc(input logic [7:0] a, input logic [31:0] e, string m);
      bus(1'b0, a, 32'h0);
      chk(q, e, m);
   endtask : rc
   function automatic logic [31:0] stat();
      return {20'h0, ef, xfer, s2, s1, par};
   endfunction : stat
   // Code expected for a fault kind seen from station o
   function automatic logic [7:0] ecode(logic [2:0] o, int k, logic [2:0] s);
      if (s == o && k != 3) return 8'h00;
      if (o == MASTER_STN)
         return k == 0 ? EC_M_WRONG : k == 1 ? EC_M_COUNT :
                k == 2 ? EC_FORMAT : k == 4 ? EC_M_TIMEOUT : 8'h00;
      if (k == 3) return EC_NO_PARAM;
      return k == 0 ? EC_O_WRONG : k == 1 ? EC_O_COUNT :
             k == 2 ? (s == MASTER_STN ? EC_S_FORMAT : EC_FORMAT) :
             k == 4 ? (s == MASTER_STN ? EC_S_TIMEOUT : EC_O_ABSENT) : 8'h00;
   endfunction : ecode
   // Kinds 0..3 fault pulses, 4 poll unanswered, 5 poll answered
   task automatic step(input int k, input logic [2:0] s);
      logic [7:0] e;
      logic [2:0] t;
      e = ecode(own, k, s);
      t = (k == 3) ? own : s;
      if (k >= 4) i_link_peer.poll(s, (k == 4) ? mt * MU + 4 : mt * MU - 3,
                                   k == 5);
      else i_link_peer.fault(k, t);
      if (e != 8'h00) begin
         ec[t] = e;
         if (!(own == MASTER_STN && t == MASTER_STN)) ef[t] = 1'b1;
      end
      rc(OFS_CODE_BASE + {t, 2'b00}, {24'h0, ec[t]}, "code");
      rc(OFS_STAT, stat(), "flags");
   endtask : step
   initial begin
      seed = 32'hD32DF595;
      miscompares = 0; comparisons = 0; ef = 8'h00; s1 = 0; s2 = 0;
      foreach (ec[i]) ec[i] = 8'h00;
      rst_b_in <= 1'b0; cyc <= 0; stb <= 0; we <= 0; adr <= 8'h00;
      wdat <= 32'h0; run <= 1'b1; xfer <= 1'b0; par <= 1'b0;
      repeat (10) @(posedge clk_in);
      rst_b_in <= 1'b1;
      @(posedge clk_in);
      rc(OFS_CTRL, 32'h0005_0000, "ctrl reset");
      rc(OFS_STAT, 32'h0, "status reset");
      for (int i = 0; i < 8; i++) rc(8'(32 + 4 * i), 32'h0, "code0");
      rc(8'h10, 32'h0, "unmapped");
      bus(1'b1, OFS_CODE_BASE, 32'hFF);
      rc(OFS_CODE_BASE, 32'h0, "code read only");
      $display("reset test done");
      for (int r = 0; r < 2; r++) begin
         own = (r == 0) ? MASTER_STN : 3'(1 + $unsigned($random(seed)) % 7);
         c = $random(seed);
         mt = (r == 0) ? 8'h03 : MON_TIME_RST;
         bus(1'b1, OFS_CTRL, {8'h00, mt, 5'h00, own, 7'h00, c});
         chk({31'h0, chs}, {31'h0, c}, "chsel");
         rc(OFS_CTRL, {8'h00, mt, 5'h00, own, 7'h00, c}, "ctrl");
         if (r == 0) step(0, MASTER_STN);
         if (r == 1) begin
            step(0, own);
            step(2, MASTER_STN);
            step(4, MASTER_STN);
            step(3, own);
         end
         for (int i = 0; i < 14; i++)
            step($unsigned($random(seed)) % 6,
                 3'(own + 1 + $unsigned($random(seed)) % 7));
         $display("role test %0d done", r);
      end
      bus(1'b1, OFS_IRQ_STAT, 32'h7);
      bus(1'b1, OFS_IRQ_MASK, 32'h1);
      chk({31'h0, irq}, 32'h0, "irq idle");
      i_link_peer.abn(2'b01);
      s1 = 1'b1;
      repeat (3) @(posedge clk_in);
      chk({31'h0, irq}, 32'h0, "irq masked");
      step(1, own ^ 3'h1);
      chk({31'h0, irq}, 32'h1, "irq seq");
      rc(OFS_IRQ_STAT, 32'h3, "irq status");
      bus(1'b1, OFS_IRQ_STAT, 32'h1);
      repeat (2) @(posedge clk_in);
      chk({31'h0, irq}, 32'h0, "irq clear");
      i_link_peer.abn(2'b10);
      s2 = 1'b1;
      xfer <= 1'b1; par <= 1'b1;
      repeat (3) @(posedge clk_in);
      rc(OFS_STAT, stat(), "latched");
      run <= 1'b0;
      @(posedge clk_in);
      run <= 1'b1;
      repeat (3) @(posedge clk_in);
      ef = 8'h00; s1 = 0; s2 = 0;
      rc(OFS_STAT, stat(), "cleared");
      for (int i = 0; i < 8; i++) rc(8'(32 + 4 * i), 32'h0, "codes");
      $display("irq and clear test done");
      end_sim();
   end
endmodule : link_error_monitor_tb
`default_nettype wire
